// >>> rtl/psl_consts.vh
// Purpose: Constants for the frame-start skew, clock output and loopback control bank.
// Assumes: APB byte address is four times the register index.
// Notes:   Definitions only.
`ifndef PSL_CONSTS_VH
`define PSL_CONSTS_VH

// ****************************************************************
// Register indices (byte address = index * 4)
// ****************************************************************
`define PSL_IDX_BASIC_MODE_CONTROL 10'h000
`define PSL_IDX_TEST_LOOP_CONTROL  10'h016
`define PSL_IDX_DEVICE_CONTROL     10'h01f
`define PSL_IDX_LANE_SKEW_STATUS   10'h055
`define PSL_IDX_ALIGN_FIFO_CONFIG  10'h0e9
`define PSL_IDX_LOOP_TUNING        10'h0fe
`define PSL_IDX_IO_CONFIG          10'h170
`define PSL_IDX_SFD_TIMING         10'h171
`define PSL_ADDR_W                 12

// ****************************************************************
// Reset values and the required alignment FIFO setting
// ****************************************************************
`define PSL_RST_BASIC_MODE_CONTROL 16'h0000
`define PSL_RST_TEST_LOOP_CONTROL  16'h0000
`define PSL_RST_DEVICE_CONTROL     16'h0000
`define PSL_RST_ALIGN_FIFO_CONFIG  16'h0000
`define PSL_RST_LOOP_TUNING        16'h0000
`define PSL_RST_IO_CONFIG          16'h0000
`define PSL_RST_SFD_TIMING         16'h0000
`define PSL_ALIGN_FIFO_GOOD        16'hdf22

// ****************************************************************
// Field positions
// ****************************************************************
`define PSL_BMC_MII_LOOP           14
`define PSL_DEV_SOFT_RESTART       14
`define PSL_TLC_MII_100_FIX        2
`define PSL_TLC_DIGITAL            3
`define PSL_TLC_ANALOG             4
`define PSL_TLC_EXTERNAL           5
`define PSL_TLC_REVERSE            6
`define PSL_TLC_MII_TO_MEDIA       9
`define PSL_IO_CLK_SEL_LSB         0
`define PSL_IO_CLK_CH_LSB          4
`define PSL_IO_CLK_DISABLE         6
`define PSL_SKW_VALID              15

// ****************************************************************
// Clock output sources and loop points
// ****************************************************************
`define PSL_CLK_REF                3'h0
`define PSL_CLK_RX125              3'h1
`define PSL_CLK_RX25               3'h2
`define PSL_CLK_LINE_TX            3'h3
`define PSL_LOOP_NONE              3'h0
`define PSL_LOOP_MII               3'h1
`define PSL_LOOP_PCS               3'h2
`define PSL_LOOP_DIGITAL           3'h3
`define PSL_LOOP_ANALOG            3'h4
`define PSL_LOOP_EXTERNAL          3'h5
`define PSL_LOOP_REVERSE           3'h6

// ****************************************************************
// Timing
// ****************************************************************
`define PSL_SKEW_STEP_NS           8
`define PSL_CLK_PERIOD_NS          8
`define PSL_SKEW_STEP_CYC          (`PSL_SKEW_STEP_NS / `PSL_CLK_PERIOD_NS)

`endif

// >>> rtl/psl_ctrl.v
// Purpose: APB register bank steering frame-start skew capture, clock output selection and
//          loopback selection of a gigabit copper transceiver.
// Assumes: Link status and alignment skew come from the PHY core on another clock and are
//          resynchronised here; the clock multiplexer itself sits outside this module.
// Notes:   Zero-wait APB slave; every access answers in the first access cycle.
`include "psl_consts.vh"

// How it works
// - Skew report constant across one unbroken link.
// - Soft restart bit re-forms link for reporting.
// - Master 1000 skew in bits 7:4.
// - Slave 1000 skew in bits 3:0.
// - No skew reported at 100 Mb.
// - Reset default clock output follows reference.
// - Clock output selects recovered 125 or 25.
// - Clock output offers line transmit, any channel.
// - Disable bit stops clock output pin.
// - Receive clock recovered; reference clocks the rest.
// - MII loop in basic control, others test.
// - Loop modes independent of speed and interface.
// - Near-end loop point chosen by control bits.
// - MII loop may also transmit to media.
// - Frame-start pulse phase adjustable, 8 ns steps.
module psl_ctrl (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        link_up,
  input  wire        speed_1000,
  input  wire        master_mode,
  input  wire [3:0]  align_skew,
  output reg  [2:0]  clk_out_sel,
  output reg  [1:0]  clk_out_chan,
  output reg         clk_out_oe,
  output reg  [2:0]  loop_mode,
  output reg         mii_loop_to_media,
  output reg         mii_loop_100_fix,
  output reg         soft_restart,
  output reg  [3:0]  rx_frame_start_pulse_phase,
  output reg  [3:0]  tx_frame_start_pulse_phase
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [15:0] basic_mode_control_q;
  reg  [15:0] test_loop_control_q;
  reg  [15:0] align_fifo_config_q;
  reg  [15:0] loop_tuning_q;
  reg  [15:0] io_config_q;
  reg  [15:0] sfd_timing_q;
  reg  [15:0] lane_skew_status_q;
  reg  [15:0] lane_skew_status_d;
  reg  [5:0]  meta_q;
  reg  [5:0]  sync_q;
  reg  [3:0]  skew_m1_q;
  reg  [3:0]  skew_m2_q;
  reg         link_prev_q;
  reg         restart_pend_q;
  reg  [15:0] rd_d;
  reg         hit_d;
  reg  [15:0] wdat;
  reg  [2:0]  loop_d;

  wire [9:0]  idx;
  wire        setup;
  wire        wr_en;
  wire        link_s;
  wire        speed_s;
  wire        master_s;
  wire        link_rise;

  assign idx       = paddr[11:2];
  assign setup     = psel & ~penable;
  assign wr_en     = psel & penable & pready & pwrite & ~pslverr;
  assign link_s    = sync_q[0];
  assign speed_s   = sync_q[1];
  assign master_s  = sync_q[2];
  assign link_rise = link_s & ~link_prev_q;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // The skew word passes two flip-flops like the link levels; the core holds it
  // steady around link-up, so the word captured at the link edge has settled.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q      <= 6'h00;
      sync_q      <= 6'h00;
      skew_m1_q   <= 4'h0;
      skew_m2_q   <= 4'h0;
      link_prev_q <= 1'b0;
    end else begin
      meta_q      <= {3'h0, master_mode, speed_1000, link_up};
      sync_q      <= meta_q;
      skew_m1_q   <= align_skew;
      skew_m2_q   <= skew_m1_q;
      link_prev_q <= link_s;
    end
  end

  // ****************************************************************
  // Write data with byte strobes
  // ****************************************************************
  always @* begin
    wdat = 16'h0000;
    case (idx)
      `PSL_IDX_BASIC_MODE_CONTROL: wdat = basic_mode_control_q;
      `PSL_IDX_TEST_LOOP_CONTROL:  wdat = test_loop_control_q;
      `PSL_IDX_ALIGN_FIFO_CONFIG:  wdat = align_fifo_config_q;
      `PSL_IDX_LOOP_TUNING:        wdat = loop_tuning_q;
      `PSL_IDX_IO_CONFIG:          wdat = io_config_q;
      `PSL_IDX_SFD_TIMING:         wdat = sfd_timing_q;
      default:                     wdat = 16'h0000;
    endcase
    if (pstrb[0]) begin
      wdat[7:0] = pwdata[7:0];
    end
    if (pstrb[1]) begin
      wdat[15:8] = pwdata[15:8];
    end
  end

  // ****************************************************************
  // Software writable registers
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      basic_mode_control_q <= `PSL_RST_BASIC_MODE_CONTROL;
      test_loop_control_q  <= `PSL_RST_TEST_LOOP_CONTROL;
      align_fifo_config_q  <= `PSL_RST_ALIGN_FIFO_CONFIG;
      loop_tuning_q        <= `PSL_RST_LOOP_TUNING;
      io_config_q          <= `PSL_RST_IO_CONFIG;
      sfd_timing_q         <= `PSL_RST_SFD_TIMING;
    end else if (wr_en) begin
      case (idx)
        `PSL_IDX_BASIC_MODE_CONTROL: basic_mode_control_q <= wdat;
        `PSL_IDX_TEST_LOOP_CONTROL:  test_loop_control_q  <= wdat;
        `PSL_IDX_ALIGN_FIFO_CONFIG:  align_fifo_config_q  <= wdat;
        `PSL_IDX_LOOP_TUNING:        loop_tuning_q        <= wdat;
        `PSL_IDX_IO_CONFIG:          io_config_q          <= wdat;
        `PSL_IDX_SFD_TIMING:         sfd_timing_q         <= wdat;
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Soft restart
  // ****************************************************************
  // Writing one to the restart bit gives a one-cycle pulse; the bit reads back as one
  // until the link has gone down and formed again, then clears itself.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_restart   <= 1'b0;
      restart_pend_q <= 1'b0;
    end else begin
      soft_restart <= wr_en && (idx == `PSL_IDX_DEVICE_CONTROL) &&
                      pstrb[1] && pwdata[`PSL_DEV_SOFT_RESTART];
      if (soft_restart) begin
        restart_pend_q <= 1'b1;
      end else if (link_rise) begin
        restart_pend_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Skew capture
  // ****************************************************************
  // Fields change only on the edge at which a link forms, so a reading stays
  // valid for the whole link. For a 1000 Mb link the valid flag records whether the alignment FIFO
  // held its required setting when that link formed; a 100 Mb link leaves it zero.
  always @* begin
    lane_skew_status_d = lane_skew_status_q;
    if (link_rise) begin
      lane_skew_status_d = 16'h0000;
      if (speed_s) begin
        lane_skew_status_d[`PSL_SKW_VALID] =
          (align_fifo_config_q == `PSL_ALIGN_FIFO_GOOD);
        if (master_s) begin
          lane_skew_status_d[7:4] = skew_m2_q;
        end else begin
          lane_skew_status_d[3:0] = skew_m2_q;
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_skew_status_q <= 16'h0000;
    end else begin
      lane_skew_status_q <= lane_skew_status_d;
    end
  end

  // ****************************************************************
  // Loop point decode
  // ****************************************************************
  // MII loop outranks the test register so that the 100 Mb fix value does not
  // also open a deeper loop.
  always @* begin
    loop_d = `PSL_LOOP_NONE;
    if (basic_mode_control_q[`PSL_BMC_MII_LOOP]) begin
      loop_d = `PSL_LOOP_MII;
    end else if (test_loop_control_q[`PSL_TLC_REVERSE]) begin
      loop_d = `PSL_LOOP_REVERSE;
    end else if (test_loop_control_q[`PSL_TLC_EXTERNAL]) begin
      loop_d = `PSL_LOOP_EXTERNAL;
    end else if (test_loop_control_q[`PSL_TLC_ANALOG]) begin
      loop_d = `PSL_LOOP_ANALOG;
    end else if (test_loop_control_q[`PSL_TLC_DIGITAL]) begin
      loop_d = `PSL_LOOP_DIGITAL;
    end else if (test_loop_control_q[`PSL_TLC_MII_100_FIX]) begin
      loop_d = `PSL_LOOP_PCS;
    end
  end

  // ****************************************************************
  // Control outputs
  // ****************************************************************
  // The loop point ignores speed and MAC interface on purpose.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_mode         <= `PSL_LOOP_NONE;
      mii_loop_to_media <= 1'b0;
      mii_loop_100_fix  <= 1'b0;
      clk_out_sel       <= `PSL_CLK_REF;
      clk_out_chan      <= 2'h0;
      clk_out_oe        <= 1'b1;
      rx_frame_start_pulse_phase      <= 4'h0;
      tx_frame_start_pulse_phase      <= 4'h0;
    end else begin
      loop_mode         <= loop_d;
      mii_loop_to_media <= basic_mode_control_q[`PSL_BMC_MII_LOOP] &
                           test_loop_control_q[`PSL_TLC_MII_TO_MEDIA];
      mii_loop_100_fix  <= basic_mode_control_q[`PSL_BMC_MII_LOOP] &
                           test_loop_control_q[`PSL_TLC_MII_100_FIX];
      clk_out_sel       <= io_config_q[`PSL_IO_CLK_SEL_LSB +: 3];
      clk_out_chan      <= io_config_q[`PSL_IO_CLK_CH_LSB +: 2];
      clk_out_oe        <= ~io_config_q[`PSL_IO_CLK_DISABLE];
      rx_frame_start_pulse_phase      <= sfd_timing_q[3:0];
      tx_frame_start_pulse_phase      <= sfd_timing_q[7:4];
    end
  end

  // ****************************************************************
  // APB read and answer
  // ****************************************************************
  always @* begin
    hit_d = 1'b1;
    rd_d  = 16'h0000;
    case (idx)
      `PSL_IDX_BASIC_MODE_CONTROL: rd_d = basic_mode_control_q;
      `PSL_IDX_TEST_LOOP_CONTROL:  rd_d = test_loop_control_q;
      `PSL_IDX_DEVICE_CONTROL:     rd_d = {1'b0, restart_pend_q, 14'h0000};
      `PSL_IDX_LANE_SKEW_STATUS:   rd_d = lane_skew_status_q;
      `PSL_IDX_ALIGN_FIFO_CONFIG:  rd_d = align_fifo_config_q;
      `PSL_IDX_LOOP_TUNING:        rd_d = loop_tuning_q;
      `PSL_IDX_IO_CONFIG:          rd_d = io_config_q;
      `PSL_IDX_SFD_TIMING:         rd_d = sfd_timing_q;
      default:                     hit_d = 1'b0;
    endcase
    if (paddr[1:0] != 2'h0) begin
      hit_d = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit_d;
      if (setup && !pwrite && hit_d) begin
        prdata <= {16'h0000, rd_d};
      end else if (setup) begin
        prdata <= 32'h00000000;
      end
    end
  end

endmodule // psl_ctrl

// >>> test/psl_host.sv
// Purpose: APB management host model for the control bank.
// Assumes: One transfer at a time; the slave may insert wait states.
// Notes:   The xfer task reports a timeout instead of hanging.
module psl_host (
  input  logic        pclk,
  input  logic [31:0] prdata,
  input  logic        pready,
  input  logic        pslverr,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0]  pstrb
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  end

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic t);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, 4'hf};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    t = (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
endmodule // psl_host

// >>> test/psl_properties.sv
// Purpose: Concurrent checks on the ports of the control bank.
// Assumes: Zero-wait APB slave; outputs follow a register write by one cycle.
// Notes:   Bound to psl_ctrl after the module.
module psl_properties (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire        pready,
  input wire        pslverr,
  input wire [2:0]  clk_out_sel,
  input wire [1:0]  clk_out_chan,
  input wire        clk_out_oe,
  input wire [2:0]  loop_mode,
  input wire        soft_restart,
  input wire [3:0]  rx_frame_start_pulse_phase,
  input wire [3:0]  tx_frame_start_pulse_phase
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr_done = psel && penable && pready && pwrite;
  wire io_wr   = wr_done && paddr == 12'h5c0 && pstrb[0];

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_misaligned_err: assert property (psel && penable && pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  a_reset_clock_ref: assert property ($rose(presetn) |-> clk_out_sel == 3'h0 && clk_out_oe)
    else $error("clock output not on reference after reset");
  a_clock_source: assert property (io_wr |-> ##2 clk_out_sel == $past(pwdata[2:0], 2)
    && clk_out_chan == $past(pwdata[5:4], 2)) else $error("clock source not applied");
  a_clock_disable: assert property (io_wr |-> ##2 clk_out_oe == !$past(pwdata[6], 2))
    else $error("clock disable not applied");
  a_mii_select: assert property (wr_done && paddr == 12'h000 && pstrb[1] |->
    ##2 (loop_mode == 3'h1) == $past(pwdata[14], 2)) else $error("mii loop select wrong");
  a_restart_pulse: assert property (wr_done && paddr == 12'h07c && pstrb[1] && pwdata[14]
    |=> soft_restart ##1 !soft_restart) else $error("restart pulse wrong");
  a_phase_step: assert property (wr_done && paddr == 12'h5c4 && pstrb[0] |-> ##2
    {tx_frame_start_pulse_phase, rx_frame_start_pulse_phase} == $past(pwdata[7:0], 2)) else $error("phase not applied");
endmodule // psl_properties

bind psl_ctrl psl_properties i_psl_properties (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .pready, .pslverr, .clk_out_sel, .clk_out_chan, .clk_out_oe,
  .loop_mode, .soft_restart, .rx_frame_start_pulse_phase, .tx_frame_start_pulse_phase);

// >>> test/tb_top.sv
// Purpose: Self-checking bench for the control bank.
// Assumes: Outputs follow a register write one cycle later.
// Notes:   Link inputs are driven directly; registers through the host model.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        link_up, speed_1000, master_mode, clk_out_oe, soft_restart;
  logic        mii_loop_to_media, mii_loop_100_fix;
  logic [1:0]  clk_out_chan;
  logic [2:0]  clk_out_sel, loop_mode;
  logic [3:0]  pstrb, align_skew, rx_frame_start_pulse_phase, tx_frame_start_pulse_phase;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int          err_total, n_compared;

  psl_ctrl i_psl_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .link_up, .speed_1000, .master_mode, .align_skew,
    .clk_out_sel, .clk_out_chan, .clk_out_oe, .loop_mode, .mii_loop_to_media,
    .mii_loop_100_fix, .soft_restart, .rx_frame_start_pulse_phase, .tx_frame_start_pulse_phase);
  psl_host i_psl_host (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb);
  always #4 pclk = ~pclk;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic stop_test;
    if (err_total == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic ee);
    logic [31:0] q;
    logic        r, t;
    i_psl_host.xfer(w, a, d, q, r, t);
    if (t) begin
      err_total++;
      stop_test();
    end else begin
      chk("slverr", {31'h0, ee}, {31'h0, r});
      if (!w) chk($sformatf("reg %h", a), e, q);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0, e, 1'b0);
  endtask
  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic link(input logic sp, input logic ms, input logic [3:0] sk);
    link_up <= 1'b0;
    repeat (4) @(posedge pclk);
    {speed_1000, master_mode, align_skew} <= {sp, ms, sk};
    @(posedge pclk);
    link_up <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    chk("clk_out_sel", 32'h0, {29'h0, clk_out_sel});
    chk("clk_out_oe", 32'h1, {31'h0, clk_out_oe});
    rd(12'h5c0, 32'h0);
    acc(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
    acc(1'b1, 12'h5c2, 32'h1, 32'h0, 1'b1);
    rd(12'h5c0, 32'h0);
  endtask
  task automatic t_clock;
    logic [3:0] k;
    for (int i = 0; i < 16; i++) begin
      k = 4'(i);
      wr(12'h5c0, {26'h0, k[3:2], 2'b00, k[1:0]});
      settle();
      chk("clk_out_sel", {30'h0, k[1:0]}, {29'h0, clk_out_sel});
      chk("clk_out_chan", {30'h0, k[3:2]}, {30'h0, clk_out_chan});
    end
    wr(12'h5c0, 32'h40);
    settle();
    chk("clk_out_oe", 32'h0, {31'h0, clk_out_oe});
    rd(12'h5c0, 32'h40);
    wr(12'h5c0, 32'h0);
    settle();
    chk("clk_out_oe", 32'h1, {31'h0, clk_out_oe});
  endtask
  task automatic t_loop;
    wr(12'h000, 32'h0);
    wr(12'h3f8, 32'he720);
    rd(12'h3f8, 32'he720);
    for (int i = 2; i < 7; i++) begin
      wr(12'h058, 32'h1 << i);
      settle();
      chk("loop_mode", i, {29'h0, loop_mode});
    end
    wr(12'h000, 32'h4000);
    wr(12'h058, 32'h4);
    settle();
    chk("loop_mode", 32'h1, {29'h0, loop_mode});
    chk("mii_loop_100_fix", 32'h1, {31'h0, mii_loop_100_fix});
    wr(12'h058, 32'h200);
    settle();
    chk("mii_loop_to_media", 32'h1, {31'h0, mii_loop_to_media});
    wr(12'h000, 32'h0);
    wr(12'h058, 32'h0);
    settle();
    chk("loop_mode", 32'h0, {29'h0, loop_mode});
  endtask
  task automatic t_skew;
    wr(12'h3a4, 32'hdf22);
    link(1'b1, 1'b1, 4'h5);
    rd(12'h154, 32'h8050);
    align_skew <= 4'h9;
    wr(12'h154, 32'hffff);
    rd(12'h154, 32'h8050);
    link(1'b1, 1'b0, 4'h3);
    rd(12'h154, 32'h8003);
    wr(12'h07c, 32'h4000);
    rd(12'h07c, 32'h4000);
    link(1'b0, 1'b0, 4'h7);
    rd(12'h154, 32'h0);
    rd(12'h07c, 32'h0);
  endtask
  task automatic t_phase;
    wr(12'h5c4, 32'ha3);
    settle();
    chk("rx_frame_start_pulse_phase", 32'h3, {28'h0, rx_frame_start_pulse_phase});
    chk("tx_frame_start_pulse_phase", 32'ha, {28'h0, tx_frame_start_pulse_phase});
    rd(12'h5c4, 32'ha3);
  endtask

  initial begin
    {pclk, presetn, link_up, speed_1000, master_mode, align_skew} = '0;
    err_total = 0;
    n_compared = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    t_reset();
    t_clock();
    t_loop();
    t_skew();
    t_phase();
    stop_test();
  end
endmodule // tb_top
